// ---- core/nps_sequencer.sv ----
`timescale 1ns/100ps
module nps_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [6:0] command_code,
  input wire logic command_execute_bit,
  input wire logic link_write,
  input wire logic [23:0] link_addr,
  input wire logic self_trigger,
  input wire logic config_change_unlock,
  input wire logic lock_active,
  input wire logic [15:0] io_addr,
  output logic io_select,
  output logic busy,
  output logic memory_path_enable_bit,
  output logic [23:0] nvm_data,
  output logic [2:0] array_op,
  output logic [1:0] array_space,
  output logic [23:0] array_addr,
  output logic array_start,
  input wire logic array_done,
  input wire logic crc_byte_valid,
  input wire logic [7:0] crc_byte
);
  import nps_pkg::*;

  nps_state_e state, next_state;
  logic [2:0] op, next_op;
  logic [1:0] space, next_space;
  logic [23:0] addr, next_addr;
  logic [23:0] crc, next_crc;
  logic [23:0] data, next_data;
  logic full_crc, next_full_crc;
  logic start, next_start;
  logic ew, next_ew;

  // one crc byte step, shared by section and full checks
  function automatic logic [23:0] crc_step(input logic [23:0] c,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = c ^ {b, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      r = r[23] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // register block window
  assign io_select = (io_addr >= NVM_BASE) &&
                     (io_addr < NVM_BASE + NVM_SPAN);

  // decoded command kind and space
  logic cmd_exec, cmd_link;
  logic [2:0] cmd_op;
  logic [1:0] cmd_space;
  logic cmd_ew, cmd_full;
  always_comb begin
    cmd_op = OP_NONE;
    cmd_space = SPC_APP;
    cmd_exec = 1'b0;
    cmd_link = 1'b0;
    cmd_ew = 1'b0;
    cmd_full = 1'b0;
    unique case (command_code)
      CMD_ERASE_PG_APP, CMD_ERASE_PG_BOOT, CMD_ERASE_PG_EE: begin
        cmd_op = OP_ERASE_PG;
        cmd_exec = 1'b1;
        cmd_link = 1'b1;
      end
      CMD_WRITE_PG_APP, CMD_WRITE_PG_BOOT, CMD_WRITE_PG_EE: begin
        cmd_op = OP_WRITE_PG;
        cmd_link = 1'b1;
      end
      CMD_EW_PG_APP, CMD_EW_PG_BOOT, CMD_EW_PG_EE: begin
        cmd_op = OP_ERASE_PG;
        cmd_ew = 1'b1;
        cmd_link = 1'b1;
      end
      CMD_ERASE_APP, CMD_ERASE_BOOT, CMD_ERASE_EE: begin
        cmd_op = OP_ERASE_SEC;
        cmd_exec = 1'b1;
      end
      CMD_CRC_APP, CMD_CRC_BOOT, CMD_CRC_FLASH: begin
        cmd_op = OP_CRC;
        cmd_exec = 1'b1;
        cmd_full = (command_code == CMD_CRC_FLASH);
      end
      CMD_WRITE_FUSE: begin
        cmd_op = OP_FUSE;
        cmd_space = SPC_FUSE;
        cmd_link = 1'b1;
      end
      CMD_WRITE_LOCK: begin
        cmd_op = OP_LOCK;
        cmd_space = SPC_FUSE;
        cmd_exec = 1'b1;
      end
      default: ;
    endcase
    // space from command group
    if (command_code == CMD_ERASE_PG_BOOT ||
        command_code == CMD_WRITE_PG_BOOT ||
        command_code == CMD_EW_PG_BOOT || command_code == CMD_ERASE_BOOT ||
        command_code == CMD_CRC_BOOT) begin
      cmd_space = SPC_BOOT;
    end else if (command_code == CMD_ERASE_PG_EE ||
                 command_code == CMD_WRITE_PG_EE ||
                 command_code == CMD_EW_PG_EE ||
                 command_code == CMD_ERASE_EE) begin
      cmd_space = SPC_EE;
    end
  end

  // self-triggered section crc needs the unlock window; full crc does not
  logic crc_locked_out;
  assign crc_locked_out = self_trigger && !config_change_unlock &&
                          (command_code == CMD_CRC_APP ||
                           command_code == CMD_CRC_BOOT);

  // triggers, swallowed while an operation runs
  logic go;
  assign go = (state == NPS_IDLE) &&
              ((command_execute_bit && cmd_exec && !crc_locked_out) ||
               (link_write && cmd_link));

  // sequencer next state
  always_comb begin
    next_state = state;
    next_op = op;
    next_space = space;
    next_addr = addr;
    next_crc = crc;
    next_data = data;
    next_full_crc = full_crc;
    next_ew = ew;
    next_start = 1'b0;
    unique case (state)
      NPS_IDLE: begin
        if (go) begin
          next_op = cmd_op;
          next_space = cmd_space;
          next_addr = link_write ? link_addr : 24'h00_0000;
          next_ew = cmd_ew;
          next_full_crc = cmd_full;
          next_crc = CRC_SEED;
          next_start = 1'b1;
          // crc ignores lock bits; lock_active never gates it
          next_state = (cmd_op == OP_CRC) ? NPS_CRC :
                       (cmd_op == OP_WRITE_PG) ? NPS_WRITE : NPS_ERASE;
        end
      end
      NPS_ERASE: begin
        if (array_done) begin
          if (ew) begin
            // atomic: chained write, busy never drops between
            next_op = OP_WRITE_PG;
            next_ew = 1'b0;
            next_start = 1'b1;
            next_state = NPS_WRITE;
          end else begin
            next_state = NPS_DONE;
          end
        end
      end
      NPS_WRITE: begin
        if (array_done) begin
          next_state = NPS_DONE;
        end
      end
      NPS_CRC: begin
        if (crc_byte_valid) begin
          next_crc = crc_step(crc, crc_byte);
        end
        if (array_done) begin
          next_data = crc_byte_valid ? crc_step(crc, crc_byte) : crc;
          next_state = NPS_DONE;
        end
      end
      NPS_DONE: begin
        next_op = OP_NONE;
        next_full_crc = 1'b0;
        next_state = NPS_IDLE;
      end
      default: next_state = NPS_IDLE;
    endcase
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= NPS_IDLE;
      op <= OP_NONE;
      space <= SPC_APP;
      addr <= 24'h00_0000;
      crc <= CRC_SEED;
      data <= 24'h00_0000;
      full_crc <= 1'b0;
      ew <= 1'b0;
      start <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      op <= next_op;
      space <= next_space;
      addr <= next_addr;
      crc <= next_crc;
      data <= next_data;
      full_crc <= next_full_crc;
      ew <= next_ew;
      start <= next_start;
    end
  end

  // outputs; busy spans start to done inclusive
  assign busy = (state != NPS_IDLE);
  assign memory_path_enable_bit = !full_crc;
  assign nvm_data = data;
  assign array_op = op;
  assign array_space = space;
  assign array_addr = addr;
  assign array_start = start;

  AST_BUSY_ON_GO: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && go) |=> busy) else $error("busy not raised");
  AST_IGNORE_BUSY: assert property (@(posedge clk)
    disable iff (!rst_n)
    (busy && clk_en && state != NPS_DONE)
    |=> $stable(op) || state == NPS_WRITE)
    else $error("trigger disturbed busy op");
  AST_PATH_OFF: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && go && cmd_full) |=> !memory_path_enable_bit && busy)
    else $error("path not cut for full crc");
  AST_PATH_ON_IDLE: assert property (@(posedge clk)
    disable iff (!rst_n)
    !busy |-> memory_path_enable_bit) else $error("path off when idle");
  AST_CRC_DATA: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && state == NPS_CRC && array_done && !crc_byte_valid)
    |=> nvm_data == $past(crc)) else $error("crc not stored");
  AST_EW_CHAIN: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && state == NPS_ERASE && ew && array_done)
    |=> state == NPS_WRITE && array_start && busy)
    else $error("erase-write not chained");
  AST_WRITE_LINK: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && !busy && link_write && command_code == CMD_WRITE_PG_APP)
    |=> array_op == OP_WRITE_PG && array_addr == $past(link_addr))
    else $error("page write not started");
  AST_SEC_ERASE: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && !busy && command_execute_bit && command_code == CMD_ERASE_EE)
    |=> array_op == OP_ERASE_SEC && array_space == SPC_EE)
    else $error("section erase not started");
  AST_CRC_UNLOCK: assert property (@(posedge clk)
    disable iff (!rst_n)
    (clk_en && !busy && command_execute_bit && self_trigger &&
     !config_change_unlock && command_code == CMD_CRC_APP && !link_write)
    |=> !busy) else $error("crc ran without unlock");
  AST_BASE: assert property (@(posedge clk)
    disable iff (!rst_n)
    (io_addr == NVM_BASE) |-> io_select) else $error("base not decoded");
endmodule // nps_sequencer

// ---- shared/nps_pkg.sv ----
package nps_pkg;
  // command codes (7-bit command field)
  localparam logic [6:0] CMD_NOP = 7'h00;
  localparam logic [6:0] CMD_ERASE_PG_APP = 7'h22;
  localparam logic [6:0] CMD_ERASE_PG_BOOT = 7'h2A;
  localparam logic [6:0] CMD_ERASE_PG_EE = 7'h32;
  localparam logic [6:0] CMD_WRITE_PG_APP = 7'h24;
  localparam logic [6:0] CMD_WRITE_PG_BOOT = 7'h2C;
  localparam logic [6:0] CMD_WRITE_PG_EE = 7'h34;
  localparam logic [6:0] CMD_EW_PG_APP = 7'h25;
  localparam logic [6:0] CMD_EW_PG_BOOT = 7'h2D;
  localparam logic [6:0] CMD_EW_PG_EE = 7'h35;
  localparam logic [6:0] CMD_ERASE_APP = 7'h20;
  localparam logic [6:0] CMD_ERASE_BOOT = 7'h68;
  localparam logic [6:0] CMD_ERASE_EE = 7'h30;
  localparam logic [6:0] CMD_CRC_APP = 7'h38;
  localparam logic [6:0] CMD_CRC_BOOT = 7'h39;
  localparam logic [6:0] CMD_CRC_FLASH = 7'h78;
  localparam logic [6:0] CMD_WRITE_FUSE = 7'h4C;
  localparam logic [6:0] CMD_WRITE_LOCK = 7'h08;
  // controller register block base in peripheral i/o space
  localparam logic [15:0] NVM_BASE = 16'h01C0;
  localparam logic [15:0] NVM_SPAN = 16'h0040;
  // memory space selectors
  localparam logic [1:0] SPC_APP = 2'h0;
  localparam logic [1:0] SPC_BOOT = 2'h1;
  localparam logic [1:0] SPC_EE = 2'h2;
  localparam logic [1:0] SPC_FUSE = 2'h3;
  // operation kinds presented to the array
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_ERASE_PG = 3'h1;
  localparam logic [2:0] OP_WRITE_PG = 3'h2;
  localparam logic [2:0] OP_ERASE_SEC = 3'h3;
  localparam logic [2:0] OP_CRC = 3'h4;
  localparam logic [2:0] OP_FUSE = 3'h5;
  localparam logic [2:0] OP_LOCK = 3'h6;
  localparam logic [23:0] CRC_SEED = 24'h00_0000;
  localparam logic [23:0] CRC_POLY = 24'h80_001B;
  typedef enum logic [2:0] {
    NPS_IDLE = 3'b000,
    NPS_ERASE = 3'b001,
    NPS_WRITE = 3'b011,
    NPS_CRC = 3'b010,
    NPS_DONE = 3'b110
  } nps_state_e;
endpackage

// ---- verification/nps_array_model.sv ----
`timescale 1ns/100ps
// array stand-in: ends each op after LAT cycles, crc ops after LAT+NB cycles, streaming NB bytes
module nps_array_model import nps_pkg::*; #(
  parameter int LAT = 3,
  parameter int NB = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic array_start,
  input wire logic [2:0] array_op,
  output logic array_done,
  output logic crc_byte_valid,
  output logic [7:0] crc_byte
);
  int cnt;
  logic crc;
  // byte lines toggle when idle so stale data never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      crc <= 1'b0;
      array_done <= 1'b0;
      crc_byte_valid <= 1'b0;
      crc_byte <= 8'h00;
    end else begin
      array_done <= 1'b0;
      crc_byte_valid <= 1'b0;
      crc_byte <= ~crc_byte;
      if (array_start) begin
        cnt <= 1;
        crc <= (array_op == OP_CRC);
      end else if (cnt > 0) begin
        cnt <= cnt + 1;
        if (crc && cnt <= NB) begin
          crc_byte_valid <= 1'b1;
          crc_byte <= 8'h30 + 8'(cnt);
        end
        if (cnt == LAT + (crc ? NB : 0)) begin
          array_done <= 1'b1;
          cnt <= 0;
        end
      end
    end
  end
endmodule // nps_array_model

// ---- verification/nvm_program_command_sequencer_tb.sv ----
`timescale 1ns/100ps
module nvm_program_command_sequencer_tb;
  import nps_pkg::*;
  logic clk, rst_n, cx, lw, st, unl, lock, pen_low, bz_bad, ce;
  logic io_sel, busy, pen, ast, adone, cbv;
  logic [6:0] cmd;
  logic [23:0] la, ad0, nd, aa;
  logic [15:0] ioa;
  logic [2:0] aop;
  logic [1:0] asp, sp0;
  logic [7:0] cb;
  logic [2:0] ops[$];
  logic [15:0] adr[4] = '{16'h01BF, 16'h01C0, 16'h01FF, 16'h0200};
  int fail_count, tests_run, cyc;

  nps_sequencer dut (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .command_code(cmd), .command_execute_bit(cx), .link_write(lw),
    .link_addr(la), .self_trigger(st), .config_change_unlock(unl),
    .lock_active(lock), .io_addr(ioa), .io_select(io_sel), .busy(busy),
    .memory_path_enable_bit(pen), .nvm_data(nd), .array_op(aop),
    .array_space(asp), .array_addr(aa), .array_start(ast),
    .array_done(adone), .crc_byte_valid(cbv), .crc_byte(cb));

  nps_array_model arr (.clk(clk), .rst_n(rst_n), .array_start(ast),
    .array_op(aop), .array_done(adone), .crc_byte_valid(cbv),
    .crc_byte(cb));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // reference checksum of the model's byte stream, msb first
  function automatic logic [23:0] crc_exp();
    logic [23:0] r;
    logic [7:0] d;
    r = CRC_SEED;
    for (int k = 1; k <= 4; k++) begin
      d = 8'h30 + 8'(k);
      for (int b = 7; b >= 0; b--) begin
        r = {r[22:0], 1'b0} ^ ((r[23] ^ d[b]) ? CRC_POLY : 24'h00_0000);
      end
    end
    return r;
  endfunction

  // watch array starts, busy at each start and path enable while busy
  always @(posedge clk) begin
    cyc++;
    if (ast === 1'b1) begin
      if (ops.size() == 0) begin
        sp0 = asp;
        ad0 = aa;
      end
      ops.push_back(aop);
      if (busy !== 1'b1) bz_bad = 1'b1;
    end
    if (busy === 1'b1 && pen !== 1'b1) pen_low = 1'b1;
    if (cyc > 5000) begin
      fail_count++;
      results();
    end
  end

  // how: 0 execute bit, 1 link write, 2 self trigger; retrigger while busy
  task automatic r(logic [6:0] c, int how, logic [2:0] e0, logic [2:0] e1,
      int ks, logic [1:0] sp, logic [23:0] a);
    int n;
    n = 0;
    ops = {};
    pen_low = 1'b0;
    bz_bad = 1'b0;
    @(posedge clk);
    cmd <= c;
    la <= a;
    cx <= (how != 1);
    lw <= (how == 1);
    st <= (how == 2);
    @(posedge clk);
    cx <= 1'b0;
    lw <= 1'b0;
    st <= 1'b0;
    @(posedge clk);
    // retrigger while busy, but no access while the path is cut
    cx <= pen;
    lw <= pen;
    @(posedge clk);
    cx <= 1'b0;
    lw <= 1'b0;
    #1;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("starts", 24'(ops.size()),
          (e1 == OP_NONE) ? 24'h00_0001 : 24'h00_0002);
    check("op0", ops[0], e0);
    if (e1 != OP_NONE) check("op1", ops[1], e1);
    if (ks) check("space", sp0, sp);
    if (how == 1) check("addr", ad0, a);
    check("busy", {bz_bad, busy}, '0);
  endtask

  // idle state after any reset
  task automatic idle_checks();
    check("reset_busy", busy, '0);
    check("reset_path", pen, 24'h00_0001);
    check("reset_data", nd, '0);
  endtask

  // reset between runs, so the next checksum must be stored afresh
  task automatic mid_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    idle_checks();
  endtask

  // register window edges around the controller block
  task automatic t_decode();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ioa <= adr[i];
      #1;
      check("io_select", io_sel, 24'(i == 1 || i == 2));
    end
    $display("test decode done");
  endtask

  // with the clock enable low a trigger must leave no trace
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    cmd <= CMD_ERASE_APP;
    cx <= 1'b1;
    @(posedge clk);
    cx <= 1'b0;
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check("frozen", busy, '0);
    $display("test freeze done");
  endtask

  // page erase by execute bit and by link write, one per space
  task automatic t_erase_page();
    r(CMD_ERASE_PG_APP, 0, OP_ERASE_PG, OP_NONE,
      1, SPC_APP, '0);
    r(CMD_ERASE_PG_BOOT, 1, OP_ERASE_PG, OP_NONE,
      1, SPC_BOOT, 24'h00_0141);
    r(CMD_ERASE_PG_EE, 0, OP_ERASE_PG, OP_NONE,
      1, SPC_EE, '0);
    $display("test erase page done");
  endtask

  // page write by link write anywhere in the page
  task automatic t_write_page();
    r(CMD_WRITE_PG_APP, 1, OP_WRITE_PG, OP_NONE,
      1, SPC_APP, 24'h00_02FF);
    r(CMD_WRITE_PG_BOOT, 1, OP_WRITE_PG, OP_NONE,
      1, SPC_BOOT, 24'h01_0000);
    r(CMD_WRITE_PG_EE, 1, OP_WRITE_PG, OP_NONE,
      1, SPC_EE, 24'h00_001F);
    $display("test write page done");
  endtask

  // erase then write, chained under one busy span
  task automatic t_erase_write();
    r(CMD_EW_PG_APP, 1, OP_ERASE_PG, OP_WRITE_PG,
      1, SPC_APP, 24'h00_0080);
    r(CMD_EW_PG_BOOT, 1, OP_ERASE_PG, OP_WRITE_PG,
      1, SPC_BOOT, 24'h00_0001);
    r(CMD_EW_PG_EE, 1, OP_ERASE_PG, OP_WRITE_PG,
      1, SPC_EE, 24'hFF_FFFF);
    $display("test erase write done");
  endtask

  // whole-section erase by execute bit
  task automatic t_section_erase();
    r(CMD_ERASE_APP, 0, OP_ERASE_SEC, OP_NONE,
      1, SPC_APP, '0);
    r(CMD_ERASE_BOOT, 0, OP_ERASE_SEC, OP_NONE,
      1, SPC_BOOT, '0);
    r(CMD_ERASE_EE, 0, OP_ERASE_SEC, OP_NONE,
      1, SPC_EE, '0);
    $display("test section erase done");
  endtask

  // fuse write by link write, lock bits by execute bit
  task automatic t_fuse_lock();
    r(CMD_WRITE_FUSE, 1, OP_FUSE, OP_NONE,
      1, SPC_FUSE, 24'h00_0002);
    r(CMD_WRITE_LOCK, 0, OP_LOCK, OP_NONE,
      1, SPC_FUSE, '0);
    $display("test fuse lock done");
  endtask

  // on-chip trigger without the unlock window must be dropped
  task automatic t_crc_app();
    @(posedge clk);
    cmd <= CMD_CRC_APP;
    cx <= 1'b1;
    st <= 1'b1;
    @(posedge clk);
    cx <= 1'b0;
    st <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("locked_out", busy, '0);
    @(posedge clk);
    unl <= 1'b1;
    r(CMD_CRC_APP, 2, OP_CRC, OP_NONE, 1, SPC_APP, '0);
    check("crc_app", nd, crc_exp());
    check("path_app", pen_low, '0);
    $display("test crc app done");
  endtask

  // boot section checksum into a cleared data register
  task automatic t_crc_boot();
    mid_reset();
    r(CMD_CRC_BOOT, 0, OP_CRC, OP_NONE, 1, SPC_BOOT, '0);
    check("crc_boot", nd, crc_exp());
    $display("test crc boot done");
  endtask

  // full checksum with locks set; path cut, then polled back
  task automatic t_crc_flash();
    mid_reset();
    @(posedge clk);
    lock <= 1'b1;
    r(CMD_CRC_FLASH, 0, OP_CRC, OP_NONE, 0, SPC_APP, '0);
    check("crc_flash", nd, crc_exp());
    check("path_cut", pen_low, 24'h00_0001);
    for (int n = 0; n < 20 && pen !== 1'b1; n++) @(posedge clk);
    check("path_back", pen, 24'h00_0001);
    $display("test crc flash done");
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {cx, lw, st, unl, lock} = 5'h00;
    cmd = CMD_NOP;
    la = 24'h00_0000;
    ioa = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    idle_checks();
    $display("test reset done");
    t_decode();
    t_freeze();
    t_erase_page();
    t_write_page();
    t_erase_write();
    t_section_erase();
    t_fuse_lock();
    t_crc_app();
    t_crc_boot();
    t_crc_flash();
    results();
  end
endmodule // nvm_program_command_sequencer_tb
